// File: plp_board_model.sv
// board-side model of the four pins: pull-ups plus an external driver
`timescale 1ns/1ns
module plp_board_model #(
  parameter NPIN = 4
) (
  input wire [NPIN-1:0] pin_o,
  input wire [NPIN-1:0] pin_oe,
  input wire [NPIN-1:0] ext_en,
  input wire [NPIN-1:0] ext_val,
  output logic [NPIN-1:0] pin_i
);
  // device drive wins, then the board driver, else the pull-up lifts a released line
  always_comb begin
    for (int k = 0; k < NPIN; k++) begin
      pin_i[k] = pin_oe[k] ? pin_o[k] : (ext_en[k] ? ext_val[k] : 1'b1);
    end
  end
endmodule

// File: plp_low_pin_group.v
// configuration, data and wake logic for the lowest four general-purpose pins
`timescale 1ns/1ns
`include "plp_regs.vh"
module plp_low_pin_group #(
  parameter NPIN = 4
) (
  input wire aclk,
  input wire aresetn,
  // register bus: write address, data and response
  input wire [`PLP_ADDR_W-1:0] s_axil_awaddr,
  input wire [2:0] s_axil_awprot,
  input wire s_axil_awvalid,
  output reg s_axil_awready,
  input wire [31:0] s_axil_wdata,
  input wire [3:0] s_axil_wstrb,
  input wire s_axil_wvalid,
  output reg s_axil_wready,
  output reg [1:0] s_axil_bresp,
  output reg s_axil_bvalid,
  input wire s_axil_bready,
  // register bus: read address and data
  input wire [`PLP_ADDR_W-1:0] s_axil_araddr,
  input wire [2:0] s_axil_arprot,
  input wire s_axil_arvalid,
  output reg s_axil_arready,
  output reg [31:0] s_axil_rdata,
  output reg [1:0] s_axil_rresp,
  output reg s_axil_rvalid,
  input wire s_axil_rready,
  // image loader; the levels count only on the done pulse
  input wire image_load_done,
  input wire eeprom_present,
  input wire [15:0] eeprom_image,
  input wire otp_programmed,
  input wire [15:0] otp_image,
  // reload sources, both one-cycle pulses
  input wire usb_bus_reset,
  input wire lite_soft_reset,
  // pads; the pin input comes from outside the clock domain
  input wire [NPIN-1:0] pin_i,
  output wire [NPIN-1:0] pin_o,
  output wire [NPIN-1:0] pin_oe,
  // event levels that follow the filtered pads
  output reg [NPIN-1:0] gpio_int_source,
  output reg wake_event
);
  // ***********************************************************
  // state
  // ***********************************************************
  // configuration fields, one bit per pin
  reg [NPIN-1:0] pin_function_select;
  reg [NPIN-1:0] output_driver_type;
  reg [NPIN-1:0] pin_direction;
  reg [NPIN-1:0] pin_level;

  // wake unit and control register
  reg [NPIN-1:0] wake_enable;
  reg [NPIN-1:0] wake_polarity;
  reg reset_protect;
  reg lite_reset_req;

  // image last loaded, kept for later reloads
  reg [15:0] image;

  // write halves held until both have arrived
  reg aw_got;
  reg w_got;
  reg [`PLP_ADDR_W-1:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  // filtered pads and image selection
  wire [NPIN-1:0] pin_sampled;
  wire [15:0] fixed_image;
  wire [15:0] next_image;
  wire reload;

  // write strobes per register
  wire do_write;
  wire wr_cfg;
  wire wr_wake;
  wire wr_ctrl;

  // read mux output
  reg [31:0] read_word;
  reg read_ok;
  genvar i;

  // ***********************************************************
  // pin inputs and pin drivers
  // ***********************************************************
  // the read path and the wake path share this one filtered copy,
  // so a pin never reads back one level and wakes on the other
  plp_sync #(
    .WIDTH(NPIN)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(pin_i),
    .sync_out(pin_sampled)
  );

  // one driver per pin, each registered
  // pad control stays in its own module, apart from the bus logic
  generate
    for (i = 0; i < NPIN; i = i + 1) begin : g_pin
      plp_pin_drive u_drive (
        .aclk(aclk),
        .aresetn(aresetn),
        .func_sel(pin_function_select[i]),
        .drv_push_pull(output_driver_type[i]),
        .dir_out(pin_direction[i]),
        .level(pin_level[i]),
        .pin_o(pin_o[i]),
        .pin_oe(pin_oe[i])
      );
    end
  endgenerate

  // ***********************************************************
  // default image selection
  // ***********************************************************
  // the same constants are the reset value of the kept image
  assign fixed_image = {`PLP_FSEL_DEF, `PLP_DRV_DEF, `PLP_DIR_DEF, `PLP_LVL_DEF};
  // eeprom wins over otp, otp over the fixed constants
  // the choice is made on the done pulse, so late image levels are harmless
  assign next_image = eeprom_present ? eeprom_image : otp_programmed ? otp_image : fixed_image;

  // a protected block ignores both reset sources
  // a usb reset held high reloads every clock and masks configuration register writes
  assign reload = (usb_bus_reset || lite_reset_req) && !reset_protect;

  // ***********************************************************
  // write channel decode
  // ***********************************************************
  // nothing changes until both halves are held; a pending response blocks a repeat
  assign do_write = aw_got && w_got && !s_axil_bvalid;
  assign wr_cfg = do_write && (aw_addr == `PLP_OFS_CFG);
  assign wr_wake = do_write && (aw_addr == `PLP_OFS_WAKE);
  assign wr_ctrl = do_write && (aw_addr == `PLP_OFS_CTRL);

  // last loaded image, kept for later usb or lite resets
  // only the done pulse moves it; the two reset sources only read it
  always @(posedge aclk) begin
    if (!aresetn) begin
      image <= {`PLP_FSEL_DEF, `PLP_DRV_DEF, `PLP_DIR_DEF, `PLP_LVL_DEF};
    end else if (image_load_done) begin
      image <= next_image;
    end
  end

  // ***********************************************************
  // configuration register; image load and reload beat a software write
  // a write that loses to a reload still answers okay; it simply has no effect
  // ***********************************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_function_select <= `PLP_FSEL_DEF;
      output_driver_type <= `PLP_DRV_DEF;
      pin_direction <= `PLP_DIR_DEF;
      pin_level <= `PLP_LVL_DEF;
    end else if (image_load_done) begin
      // the loader wins, its image being the new default
      pin_function_select <= next_image[`PLP_FSEL_LSB +: NPIN];
      output_driver_type <= next_image[`PLP_DRV_LSB +: NPIN];
      pin_direction <= next_image[`PLP_DIR_LSB +: NPIN];
      pin_level <= next_image[`PLP_LVL_LSB +: NPIN];
    end else if (reload) begin
      pin_function_select <= image[`PLP_FSEL_LSB +: NPIN];
      output_driver_type <= image[`PLP_DRV_LSB +: NPIN];
      pin_direction <= image[`PLP_DIR_LSB +: NPIN];
      pin_level <= image[`PLP_LVL_LSB +: NPIN];
    end else if (wr_cfg) begin
      // lane 1 holds select and driver, lane 0 direction and level
      if (w_strb[1]) begin
        pin_function_select <= w_data[`PLP_FSEL_LSB +: NPIN];
        output_driver_type <= w_data[`PLP_DRV_LSB +: NPIN];
      end
      if (w_strb[0]) begin
        pin_direction <= w_data[`PLP_DIR_LSB +: NPIN];
        pin_level <= w_data[`PLP_LVL_LSB +: NPIN];
      end
    end
  end

  // ***********************************************************
  // wake enable, polarity and control registers
  // ***********************************************************
  // wake settings survive usb and lite resets; only aresetn clears them
  always @(posedge aclk) begin
    if (!aresetn) begin
      wake_enable <= `PLP_WEN_DEF;
      wake_polarity <= `PLP_WPOL_DEF;
    end else if (wr_wake) begin
      // lane 0 enables, lane 2 polarity; other lanes are dropped
      if (w_strb[0]) begin
        wake_enable <= w_data[`PLP_WEN_LSB +: NPIN];
      end
      if (w_strb[2]) begin
        wake_polarity <= w_data[`PLP_WPOL_LSB +: NPIN];
      end
    end
  end

  // lite reset bit clears itself after one cycle; the pin input also triggers it
  always @(posedge aclk) begin
    if (!aresetn) begin
      reset_protect <= 1'b0;
      lite_reset_req <= 1'b0;
    end else begin
      // pin and register share one request flop, so a clash costs nothing
      lite_reset_req <= lite_soft_reset || (wr_ctrl && w_strb[0] && w_data[`PLP_CTRL_LITE_RST_BIT]);
      // protection is a plain stored bit; it only gates the two reload sources
      if (wr_ctrl && w_strb[0]) begin
        reset_protect <= w_data[`PLP_CTRL_PROT_BIT];
      end
    end
  end

  // ***********************************************************
  // wake and interrupt qualification
  // ***********************************************************
  // an input pin in gpio function matching its polarity is an active source
  // a pin turned output drops out on the next clock, not after its pad settles
  always @(posedge aclk) begin
    if (!aresetn) begin
      gpio_int_source <= {NPIN{1'b0}};
      wake_event <= 1'b0;
    end else begin
      // polarity 1 means active high, 0 active low
      gpio_int_source <= ~pin_function_select & ~pin_direction & ~(pin_sampled ^ wake_polarity);
      wake_event <= |(~pin_function_select & ~pin_direction & wake_enable & ~(pin_sampled ^ wake_polarity));
    end
  end

  // ***********************************************************
  // bus write side: address and data taken in either order
  // ***********************************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      // both readies open in reset so the first write waits for nothing
      s_axil_awready <= 1'b1;
      s_axil_wready <= 1'b1;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= {`PLP_ADDR_W{1'b0}};
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axil_bvalid <= 1'b0;
      s_axil_bresp <= `PLP_RESP_OKAY;
    end else begin
      if (s_axil_awvalid && s_axil_awready) begin
        aw_got <= 1'b1;
        // byte address bits below the word are ignored
        aw_addr <= {s_axil_awaddr[`PLP_ADDR_W-1:2], 2'h0};
        s_axil_awready <= 1'b0;
      end
      if (s_axil_wvalid && s_axil_wready) begin
        w_got <= 1'b1;
        w_data <= s_axil_wdata;
        w_strb <= s_axil_wstrb;
        s_axil_wready <= 1'b0;
      end
      if (do_write) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axil_bvalid <= 1'b1;
        // an unmapped address answers with an error and changes nothing
        s_axil_bresp <= (wr_cfg || wr_wake || wr_ctrl) ? `PLP_RESP_OKAY : `PLP_RESP_SLVERR;
      end
      // a new write is only opened once the response is gone
      // readies stay low from take to response, so nothing queues
      if (s_axil_bvalid && s_axil_bready) begin
        s_axil_bvalid <= 1'b0;
        s_axil_awready <= 1'b1;
        s_axil_wready <= 1'b1;
      end
    end
  end

  // ***********************************************************
  // bus read side
  // ***********************************************************
  // level field shows live pins; reserved bits read zero
  // select, driver and direction read as stored; only the level shows the pad
  always @* begin
    read_word = 32'h00000000;
    read_ok = 1'b1;
    case ({s_axil_araddr[`PLP_ADDR_W-1:2], 2'h0})
      `PLP_OFS_CFG: begin
        read_word[`PLP_FSEL_LSB +: NPIN] = pin_function_select;
        read_word[`PLP_DRV_LSB +: NPIN] = output_driver_type;
        read_word[`PLP_DIR_LSB +: NPIN] = pin_direction;
        // four clocks behind the pad; the stored level only drives outputs
        read_word[`PLP_LVL_LSB +: NPIN] = pin_sampled;
      end
      `PLP_OFS_WAKE: begin
        read_word[`PLP_WPOL_LSB +: NPIN] = wake_polarity;
        read_word[`PLP_WEN_LSB +: NPIN] = wake_enable;
      end
      `PLP_OFS_CTRL: begin
        // the lite reset bit is a strobe and reads zero
        read_word[`PLP_CTRL_PROT_BIT] = reset_protect;
      end
      default: begin
        read_ok = 1'b0;
      end
    endcase
  end

  // one read in flight; data held until the master takes it
  // data captured at the take, so later pad changes cannot tear it
  always @(posedge aclk) begin
    if (!aresetn) begin
      // ready open in reset, as on the write side
      s_axil_arready <= 1'b1;
      s_axil_rvalid <= 1'b0;
      s_axil_rdata <= 32'h00000000;
      s_axil_rresp <= `PLP_RESP_OKAY;
    end else if (s_axil_arvalid && s_axil_arready) begin
      s_axil_arready <= 1'b0;
      s_axil_rvalid <= 1'b1;
      s_axil_rdata <= read_word;
      s_axil_rresp <= read_ok ? `PLP_RESP_OKAY : `PLP_RESP_SLVERR;
    end else if (s_axil_rvalid && s_axil_rready) begin
      s_axil_rvalid <= 1'b0;
      s_axil_arready <= 1'b1;
    end
  end
endmodule

// File: plp_low_pin_group_asserts.sv
// assertion checker for the low pin group, bound to its top module
`timescale 1ns/1ns
`include "plp_regs.vh"
module plp_low_pin_group_asserts #(
  parameter NPIN = 4
) (
  input wire aclk,
  input wire aresetn,
  input wire s_axil_awvalid,
  input wire s_axil_awready,
  input wire s_axil_wvalid,
  input wire s_axil_wready,
  input wire [1:0] s_axil_bresp,
  input wire s_axil_bvalid,
  input wire s_axil_bready,
  input wire [7:0] s_axil_araddr,
  input wire s_axil_arvalid,
  input wire s_axil_arready,
  input wire [31:0] s_axil_rdata,
  input wire [1:0] s_axil_rresp,
  input wire s_axil_rvalid,
  input wire s_axil_rready,
  input wire [NPIN-1:0] pin_oe,
  input wire [NPIN-1:0] gpio_int_source,
  input wire wake_event
);
  // ***********************************************************
  // bus handshakes
  // ***********************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready;
  endsequence
  sequence s_rd_take;
    s_axil_arvalid && s_axil_arready;
  endsequence
  a_write_answer_due: assert property (s_wr_take |-> ##2 s_axil_bvalid)
    else $error("write response late");
  a_read_answer_due: assert property (s_rd_take |=> s_axil_rvalid)
    else $error("read data late");
  a_bresp_held: assert property (s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid && $stable(s_axil_bresp))
    else $error("write response dropped");
  a_rdata_held: assert property (s_axil_rvalid && !s_axil_rready |=> s_axil_rvalid && $stable(s_axil_rdata))
    else $error("read data dropped");
  a_ready_while_busy: assert property (s_axil_bvalid |-> !s_axil_awready && !s_axil_wready)
    else $error("write accepted while busy");
  // only three word addresses are mapped, the rest must be refused
  a_unmapped_read_err: assert property (s_rd_take ##0 (s_axil_araddr[7:2] != 6'h06 && s_axil_araddr[7:2] != 6'h08
    && s_axil_araddr[7:2] != 6'h09) |=> s_axil_rresp == `PLP_RESP_SLVERR)
    else $error("unmapped read not refused");
  // ***********************************************************
  // pin and wake relations
  // ***********************************************************
  a_int_not_output: assert property ((gpio_int_source & pin_oe) == '0)
    else $error("driven pin acts as event source");
  a_wake_needs_source: assert property (wake_event |-> gpio_int_source != '0)
    else $error("wake without gpio input source");
  a_reset_pins_quiet: assert property (disable iff (1'b0) !aresetn |=> pin_oe == '0 && !wake_event)
    else $error("pins driven after reset");
endmodule
bind plp_low_pin_group plp_low_pin_group_asserts #(.NPIN(NPIN)) plp_low_pin_group_asserts_i (.aclk(aclk),
  .aresetn(aresetn), .s_axil_awvalid(s_axil_awvalid), .s_axil_awready(s_axil_awready),
  .s_axil_wvalid(s_axil_wvalid), .s_axil_wready(s_axil_wready), .s_axil_bresp(s_axil_bresp),
  .s_axil_bvalid(s_axil_bvalid), .s_axil_bready(s_axil_bready), .s_axil_araddr(s_axil_araddr),
  .s_axil_arvalid(s_axil_arvalid), .s_axil_arready(s_axil_arready), .s_axil_rdata(s_axil_rdata),
  .s_axil_rresp(s_axil_rresp), .s_axil_rvalid(s_axil_rvalid), .s_axil_rready(s_axil_rready),
  .pin_oe(pin_oe), .gpio_int_source(gpio_int_source), .wake_event(wake_event));

// File: plp_pin_drive.v
// per-pin output buffer control: push/pull or open-drain
`timescale 1ns/1ns
module plp_pin_drive (
  input wire aclk,
  input wire aresetn,
  input wire func_sel,
  input wire drv_push_pull,
  input wire dir_out,
  input wire level,
  output reg pin_o,
  output reg pin_oe
);
  // ***********************************************************
  // drive only when the pin is a general-purpose output
  // ***********************************************************
  wire gp_out = !func_sel && dir_out;
  // registered so the pad sees glitch-free enables
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_o <= 1'b0;
      pin_oe <= 1'b0;
    end else if (drv_push_pull) begin
      pin_o <= level;
      pin_oe <= gp_out;
    end else begin
      pin_o <= 1'b0;
      pin_oe <= gp_out && !level;
    end
  end
endmodule

// File: plp_regs.vh
// register offsets, field positions and default values of the low pin group
`ifndef PLP_REGS_VH
`define PLP_REGS_VH
// ***********************************************************
// register byte offsets
// ***********************************************************
`define PLP_ADDR_W 8
`define PLP_OFS_CFG 8'h18
`define PLP_OFS_WAKE 8'h20
`define PLP_OFS_CTRL 8'h24
// ***********************************************************
// field positions in the configuration register
// ***********************************************************
`define PLP_FSEL_LSB 12
`define PLP_DRV_LSB 8
`define PLP_DIR_LSB 4
`define PLP_LVL_LSB 0
// ***********************************************************
// field positions in the wake and control registers
// ***********************************************************
`define PLP_WPOL_LSB 16
`define PLP_WEN_LSB 0
`define PLP_CTRL_PROT_BIT 0
`define PLP_CTRL_LITE_RST_BIT 1
// ***********************************************************
// fixed defaults used when no image is present, and the wake reset values
// ***********************************************************
`define PLP_FSEL_DEF 4'hF
`define PLP_DRV_DEF 4'h0
`define PLP_DIR_DEF 4'h0
`define PLP_LVL_DEF 4'h0
`define PLP_WPOL_DEF 4'h0
`define PLP_WEN_DEF 4'h0
// ***********************************************************
// bus response codes
// ***********************************************************
`define PLP_RESP_OKAY 2'h0
`define PLP_RESP_SLVERR 2'h2
`endif

// File: plp_sync.v
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module plp_sync #(
  parameter WIDTH = 4
) (
  input wire aclk,
  input wire aresetn,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  reg [WIDTH-1:0] stage3;
  genvar i;
  // ***********************************************************
  // per bit: stage1 feeds only stage2; a change counts once 2 and 3 agree
  // ***********************************************************
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge aclk) begin
        if (!aresetn) begin
          stage1[i] <= 1'b0;
          stage2[i] <= 1'b0;
          stage3[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          stage1[i] <= async_in[i];
          stage2[i] <= stage1[i];
          stage3[i] <= stage2[i];
          if (stage2[i] == stage3[i]) begin
            sync_out[i] <= stage3[i];
          end
        end
      end
    end
  endgenerate
endmodule

// File: tb_plp_low_pin_group.sv
// self-checking bench for the low pin group
`timescale 1ns/1ns
`include "plp_regs.vh"
module tb_plp_low_pin_group;
  logic aclk, aresetn, s_axil_awvalid, s_axil_wvalid, s_axil_bready, s_axil_arvalid, s_axil_rready;
  logic [7:0] s_axil_awaddr, s_axil_araddr;
  logic [31:0] s_axil_wdata, d;
  wire s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid, wake_event;
  wire [1:0] s_axil_bresp, s_axil_rresp;
  wire [31:0] s_axil_rdata;
  logic image_load_done, eeprom_present, otp_programmed, usb_bus_reset, lite_soft_reset;
  logic [15:0] eeprom_image, otp_image, c, img;
  logic [3:0] ext_en, ext_val, pol, en, w, be, s_axil_wstrb;
  logic [1:0] r;
  wire [3:0] pin_i, pin_o, pin_oe, gpio_int_source;
  int n_mismatch = 0;
  int compares = 0;
  logic [15:0] corner [4] = '{16'h00F5, 16'h0FFA, 16'hF0F0, 16'h0000};
  plp_low_pin_group #(.NPIN(4)) plp_low_pin_group_i (.aclk(aclk), .aresetn(aresetn),
    .s_axil_awaddr(s_axil_awaddr), .s_axil_awprot(3'h0), .s_axil_awvalid(s_axil_awvalid),
    .s_axil_awready(s_axil_awready), .s_axil_wdata(s_axil_wdata), .s_axil_wstrb(s_axil_wstrb),
    .s_axil_wvalid(s_axil_wvalid), .s_axil_wready(s_axil_wready), .s_axil_bresp(s_axil_bresp),
    .s_axil_bvalid(s_axil_bvalid), .s_axil_bready(s_axil_bready), .s_axil_araddr(s_axil_araddr),
    .s_axil_arprot(3'h0), .s_axil_arvalid(s_axil_arvalid), .s_axil_arready(s_axil_arready),
    .s_axil_rdata(s_axil_rdata), .s_axil_rresp(s_axil_rresp), .s_axil_rvalid(s_axil_rvalid),
    .s_axil_rready(s_axil_rready), .image_load_done(image_load_done), .eeprom_present(eeprom_present),
    .eeprom_image(eeprom_image), .otp_programmed(otp_programmed), .otp_image(otp_image),
    .usb_bus_reset(usb_bus_reset), .lite_soft_reset(lite_soft_reset), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe(pin_oe), .gpio_int_source(gpio_int_source), .wake_event(wake_event));
  plp_board_model #(.NPIN(4)) plp_board_model_i (.pin_o(pin_o), .pin_oe(pin_oe), .ext_en(ext_en),
    .ext_val(ext_val), .pin_i(pin_i));
  // ***********************************************************
  // clock, checks and expectations
  // ***********************************************************
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  task automatic finish_test;
    if (n_mismatch == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_pin(input string nm, input logic [3:0] e, input logic [3:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // pins driven: gpio function, output, and push-pull or a low level
  function automatic logic [3:0] f_oe(input logic [15:0] v);
    return ~v[15:12] & v[7:4] & (v[11:8] | ~v[3:0]);
  endfunction
  function automatic logic [3:0] f_wire(input logic [15:0] v, input logic [3:0] e, input logic [3:0] x);
    return (f_oe(v) & v[3:0]) | (~f_oe(v) & ((e & x) | ~e));
  endfunction
  function automatic logic [3:0] f_int(input logic [15:0] v, input logic [3:0] lv, input logic [3:0] p);
    return ~v[15:12] & ~v[7:4] & ~(lv ^ p);
  endfunction
  // ***********************************************************
  // bus master: address and data offered together, each released when taken
  // ***********************************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    s_axil_awaddr <= a;
    s_axil_wdata <= v;
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid <= 1'b1;
    s_axil_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && s_axil_awready) begin
        ad = 1'b1;
        s_axil_awvalid <= 1'b0;
      end
      if (!wd && s_axil_wready) begin
        wd = 1'b1;
        s_axil_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axil_bvalid);
    rs = s_axil_bresp;
    s_axil_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'b1;
    s_axil_rready <= 1'b1;
    do @(posedge aclk); while (!s_axil_arready);
    s_axil_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axil_rvalid);
    v = s_axil_rdata;
    rs = s_axil_rresp;
    s_axil_rready <= 1'b0;
    @(posedge aclk);
  endtask
  // one-cycle strobe: 0 usb reset, 1 lite reset, else image load
  task automatic pulse(input int k);
    case (k)
      0: usb_bus_reset <= 1'b1;
      1: lite_soft_reset <= 1'b1;
      default: image_load_done <= 1'b1;
    endcase
    @(posedge aclk);
    usb_bus_reset <= 1'b0;
    lite_soft_reset <= 1'b0;
    image_load_done <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask
  // hang guard, well beyond the under one thousand cycles the tests take
  initial begin
    #(40 * 20000);
    n_mismatch++;
    finish_test;
  end
  // ***********************************************************
  // main sequence
  // ***********************************************************
  initial begin
    {aresetn, s_axil_awvalid, s_axil_wvalid, s_axil_bready, s_axil_arvalid, s_axil_rready} = '0;
    {s_axil_awaddr, s_axil_araddr, s_axil_wdata} = '0;
    {image_load_done, eeprom_present, otp_programmed, usb_bus_reset, lite_soft_reset} = '0;
    {eeprom_image, otp_image} = '0;
    ext_en = 4'hF;
    s_axil_wstrb = 4'hF;
    ext_val = 4'h5;
    void'($urandom(32'h268F));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (7) @(posedge aclk);
    chk_pin("pin_oe reset", 4'h0, pin_oe);
    rd(`PLP_OFS_CFG, d, r);
    chk_reg("cfg default", 32'h0000F005, d);
    // corner tables first, then random configurations and board levels
    for (int i = 0; i < 28; i++) begin
      c = (i < 4) ? corner[i] : 16'($urandom);
      {pol, en, be} = 12'($urandom);
      ext_en <= be & ~f_oe(c);
      ext_val <= 4'($urandom);
      wr(`PLP_OFS_WAKE, {12'h0, pol, 12'h0, en}, r);
      wr(`PLP_OFS_CFG, {16'h0, c}, r);
      chk_reg("cfg bresp", {30'h0, `PLP_RESP_OKAY}, {30'h0, r});
      repeat (8) @(posedge aclk);
      w = f_wire(c, ext_en, ext_val);
      chk_pin("pin_oe", f_oe(c), pin_oe);
      chk_pin("pin_o", f_oe(c) & c[3:0], pin_o & pin_oe);
      chk_pin("int source", f_int(c, w, pol), gpio_int_source);
      chk_reg("wake", {31'h0, |(f_int(c, w, pol) & en)}, {31'h0, wake_event});
      rd(`PLP_OFS_CFG, d, r);
      chk_reg("cfg read", {16'h0, c[15:4], w}, d);
      rd(`PLP_OFS_WAKE, d, r);
      chk_reg("wake read", {12'h0, pol, 12'h0, en}, d);
    end
    // image source priority, then reload by each reset kind
    for (int m = 0; m < 3; m++) begin
      img = 16'($urandom);
      eeprom_image <= img;
      otp_image <= ~img;
      eeprom_present <= (m == 0);
      otp_programmed <= (m < 2);
      img = (m == 1) ? ~img : ((m == 2) ? 16'hF000 : img);
      pulse(2);
      rd(`PLP_OFS_CFG, d, r);
      chk_reg("image load", {16'h0, img[15:4], 4'h0}, {d[31:4], 4'h0});
      for (int s = 0; s < 3; s++) begin
        wr(`PLP_OFS_CFG, {16'h0, ~img}, r);
        if (s == 2) wr(`PLP_OFS_CTRL, 32'h2, r);
        else pulse(s);
        repeat (3) @(posedge aclk);
        rd(`PLP_OFS_CFG, d, r);
        chk_reg("reload", {16'h0, img[15:4], 4'h0}, {d[31:4], 4'h0});
      end
    end
    // protection blocks the reload
    wr(`PLP_OFS_CTRL, 32'h1, r);
    wr(`PLP_OFS_CFG, 32'h5A3C, r);
    pulse(0);
    pulse(1);
    rd(`PLP_OFS_CFG, d, r);
    chk_reg("protected", 32'h5A30, {d[31:4], 4'h0});
    // lane 1 alone clears select and driver, leaving direction intact
    s_axil_wstrb <= 4'h2;
    wr(`PLP_OFS_CFG, 32'h0, r);
    s_axil_wstrb <= 4'hF;
    rd(`PLP_OFS_CFG, d, r);
    chk_reg("lane one", 32'h0030, {d[31:4], 4'h0});
    rd(`PLP_OFS_CTRL, d, r);
    chk_reg("ctrl read", 32'h1, d);
    wr(8'h40, 32'($urandom), r);
    chk_reg("unmapped bresp", {30'h0, `PLP_RESP_SLVERR}, {30'h0, r});
    rd(8'h40, d, r);
    chk_reg("unmapped rresp", {30'h0, `PLP_RESP_SLVERR}, {30'h0, r});
    finish_test;
  end
endmodule
